// [src/txcd_pkg.sv]
// Constants, states and the state record of the transmit command decoder
package txcd_pkg;
  // Power-on command words
  localparam logic [15:0] FREQ_RST = 16'ha7d0;
  localparam logic [15:0] RATE_RST = 16'hc800;
  localparam logic [7:0] PWR_RST = 8'hb0;
  localparam logic [15:0] BATT_RST = 16'hc200;
  localparam logic [15:0] SLEEP_RST = 16'hc410;
  localparam logic [15:0] BTN_RST = 16'hca00;
  localparam logic [15:0] WAKE_RST = 16'he000;
  localparam logic [15:0] PM_RST = 16'hc000;
  // Command prefixes
  localparam logic [3:0] P_FREQ = 4'ha;
  localparam logic [3:0] P_PWR = 4'hb;
  localparam logic [2:0] P_WAKE = 3'h7;
  localparam logic [7:0] P_PM = 8'hc0;
  localparam logic [7:0] P_BATT = 8'hc2;
  localparam logic [7:0] P_SLEEP = 8'hc4;
  localparam logic [7:0] P_SEND = 8'hc6;
  localparam logic [7:0] P_RATE = 8'hc8;
  localparam logic [7:0] P_BTN = 8'hca;
  localparam logic [15:0] SOFT_RST = 16'hfe00;
  // Accepted carrier value range
  localparam logic [11:0] FREQ_MIN = 12'h060;
  localparam logic [11:0] FREQ_MAX = 12'hf3f;
  // Power management bit positions
  localparam int PM_A1 = 7;
  localparam int PM_A0 = 6;
  localparam int PM_EX = 5;
  localparam int PM_ES = 4;
  localparam int PM_EA = 3;
  localparam int PM_EB = 2;
  localparam int PM_ET = 1;
  localparam int PM_DC = 0;
  // Other field positions
  localparam int PWR_OOK = 3;
  localparam int BATT_DWC = 7;
  localparam int BATT_EBS = 5;
  localparam int BTN_P4 = 7;
  // Clock rates and bit-rate divider
  localparam int XTAL_HZ = 10_000_000;
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PER_XTAL = CLK_HZ / XTAL_HZ;
  localparam int RATE_DIV = 29;
  localparam logic [7:0] CMD_RD_R = 8'h02;
  localparam int HALF_BIT_UNIT = RATE_DIV * CLK_PER_XTAL / 2;
  // Debounce and recalibration times
  localparam int DEB_160_MS = 160;
  localparam int DEB_40_MS = 40;
  localparam int DEB_10_MS = 10;
  localparam int DEB_160_CYC = DEB_160_MS * (CLK_HZ / 1000);
  localparam int DEB_40_CYC = DEB_40_MS * (CLK_HZ / 1000);
  localparam int DEB_10_CYC = DEB_10_MS * (CLK_HZ / 1000);
  localparam int RECAL_S = 30;
  localparam int RECAL_CYC = RECAL_S * CLK_HZ;
  // One output-clock period of the sleep tail
  localparam int TAIL_UNIT_CYC = CLK_PER_XTAL;
  // Band constants
  localparam logic [1:0] BAND_433 = 2'b01;
  localparam logic [1:0] BAND_868 = 2'b10;
  localparam logic [1:0] BAND_915 = 2'b11;
  localparam logic [1:0] C1_433 = 2'd1;
  localparam logic [1:0] C1_868 = 2'd2;
  localparam logic [1:0] C1_915 = 2'd3;
  localparam logic [5:0] C2_433 = 6'd43;
  localparam logic [5:0] C2_868 = 6'd43;
  localparam logic [5:0] C2_915 = 6'd30;
  // Scale of derived settings
  localparam logic [4:0] ATT_STEP_DB = 5'd3;
  localparam logic [12:0] VLB_BASE_MV = 13'd2250;
  localparam logic [12:0] VLB_STEP_MV = 13'd100;

  // Power sequencer states
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_OSC = 2'b01,
    S_LOCK = 2'b10,
    S_TX = 2'b11
  } txcd_seq_e;

  // Whole state of the decoder
  typedef struct packed {
    logic [11:0] freq;
    logic [7:0] rate;
    logic ook;
    logic [2:0] patt;
    logic dwc;
    logic ebs;
    logic [4:0] thr;
    logic [7:0] tail;
    logic p4;
    logic [1:0] deb;
    logic [3:0] rpt;
    logic bc;
    logic [7:0] wm;
    logic [4:0] we;
    logic [7:0] pm;
    txcd_seq_e seq;
    logic [31:0] tmr;
    logic [7:0] nbytes;
    logic [7:0] bcnt;
    logic hdr_eem;
    logic sosc;
    logic ssyn;
    logic samp;
    logic osc;
    logic syn;
    logic amp;
    logic key;
    logic cal;
    logic stretch;
    logic txon;
    logic srst;
    logic evh;
    logic tail_on;
    logic [9:0] tail_cnt;
    logic b1a;
    logic b1b;
    logic b2a;
    logic b2b;
    logic tda;
    logic tdb;
    logic eema;
    logic eemb;
    logic [31:0] dcnt;
    logic busy;
    logic [1:0] bstab;
    logic [3:0] bprev;
    logic [3:0] bevt;
    logic irq_n;
    logic [15:0] hcnt;
    logic sck;
    logic btick;
    logic [31:0] rcnt;
    logic recal;
    logic [4:0] attdb;
    logic [12:0] vlb;
    logic [1:0] c1;
    logic [5:0] c2;
  } txcd_state_s;
endpackage : txcd_pkg

// [src/txcd_core.sv]
// Command decoder, power sequencer and event logic of the TX_DATA_PIN transmitter
`timescale 1ns/1ps
module txcd_core #(
  parameter int DEB160_CYC = txcd_pkg::DEB_160_CYC,
  parameter int DEB40_CYC = txcd_pkg::DEB_40_CYC,
  parameter int DEB10_CYC = txcd_pkg::DEB_10_CYC,
  parameter int RECAL_CYC = txcd_pkg::RECAL_CYC,
  parameter int REF_WAIT_CYC = 400,
  parameter int LOCK_WAIT_CYC = 4000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Command words
  input wire logic cmd_valid,
  input wire logic cmd_short,
  input wire logic [15:0] cmd_word,
  // Data stream from memory
  input wire logic data_byte_valid,
  // Pins
  input wire logic eeprom_mode_pin,
  input wire logic button_one_input,
  input wire logic button_two_input,
  input wire logic tx_data_pin,
  // Peripheral events and band
  input wire logic battery_monitor_low,
  input wire logic wake_timeout,
  input wire logic [1:0] band_sel,
  // Power control
  output logic osc_enable,
  output logic synth_enable,
  output logic amp_enable,
  output logic amp_key,
  output logic vco_cal,
  output logic header_stretch,
  output logic tx_active,
  output logic soft_reset,
  output logic battery_monitor_enable,
  output logic wake_timer_enable,
  // Timing
  output logic tx_bit_tick,
  output logic mem_sck,
  output logic wake_recal,
  // Settings
  output logic [11:0] freq_field,
  output logic [1:0] freq_c1,
  output logic [5:0] freq_c2,
  output logic [7:0] rate_field,
  output logic [2:0] power_atten_field,
  output logic [4:0] atten_db,
  output logic [4:0] battery_threshold_field,
  output logic [12:0] threshold_mv,
  output logic [7:0] clock_tail_count,
  output logic [7:0] wake_mantissa,
  output logic [4:0] wake_exponent,
  output logic bit_sync_enable,
  output logic [1:0] debounce_select,
  output logic pullup_enable,
  // Button events
  output logic [3:0] button_events,
  output logic interrupt_out_n
);

  txcd_pkg::txcd_state_s st;
  txcd_pkg::txcd_state_s next_st;

  //////////////////////////////////////////////////////////////////////////
  // Power-on defaults of every field
  function automatic txcd_pkg::txcd_state_s txcd_defaults();
    txcd_pkg::txcd_state_s d;
    d = '0;
    d.freq = txcd_pkg::FREQ_RST[11:0];
    d.rate = txcd_pkg::RATE_RST[7:0];
    {d.ook, d.patt} = txcd_pkg::PWR_RST[3:0];
    d.dwc = txcd_pkg::BATT_RST[txcd_pkg::BATT_DWC];
    d.ebs = txcd_pkg::BATT_RST[txcd_pkg::BATT_EBS];
    d.thr = txcd_pkg::BATT_RST[4:0];
    d.tail = txcd_pkg::SLEEP_RST[7:0];
    {d.p4, d.deb, d.rpt, d.bc} = txcd_pkg::BTN_RST[7:0];
    {d.we, d.wm} = txcd_pkg::WAKE_RST[12:0];
    d.pm = txcd_pkg::PM_RST[7:0];
    d.seq = txcd_pkg::S_IDLE;
    d.evh = 1'b1;
    d.osc = 1'b1;
    d.irq_n = 1'b1;
    // Button pins idle high, so no false press follows reset
    d.b1a = 1'b1;
    d.b1b = 1'b1;
    d.b2a = 1'b1;
    d.b2b = 1'b1;
    d.vlb = txcd_pkg::VLB_BASE_MV;
    return d;
  endfunction : txcd_defaults

  // Half period of the memory clock for divider value r
  function automatic logic [15:0] half_cyc(input logic [7:0] r);
    return 16'(txcd_pkg::HALF_BIT_UNIT * (int'(r) + 1));
  endfunction : half_cyc

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [15:0] w;
    logic hit;
    logic slp;
    logic start;
    logic [1:0] pr;
    logic [31:0] lim;
    logic combo;
    logic [3:0] held;
    logic [15:0] half;
    logic run;
    w = cmd_word;
    hit = 1'b0;
    slp = 1'b0;
    start = 1'b0;
    pr = 2'b00;
    lim = 32'd0;
    combo = 1'b0;
    held = 4'h0;
    half = 16'h0000;
    run = 1'b0;
    next_st = st;
    next_st.srst = 1'b0;
    next_st.recal = 1'b0;
    next_st.btick = 1'b0;
    // Pin synchronisers
    next_st.b1a = button_one_input;
    next_st.b1b = st.b1a;
    next_st.b2a = button_two_input;
    next_st.b2b = st.b2a;
    next_st.tda = tx_data_pin;
    next_st.tdb = st.tda;
    next_st.eema = eeprom_mode_pin;
    next_st.eemb = st.eema;
    // Memory data bytes are not commands while counted
    hit = cmd_valid && !(st.seq == txcd_pkg::S_TX && st.hdr_eem);
    // Command decode
    if (hit && cmd_short) begin
      if (w[7:4] == txcd_pkg::P_PWR) begin
        {next_st.ook, next_st.patt} = w[3:0];
      end else if (w[7:0] == txcd_pkg::P_SEND) begin
        start = 1'b1;
        next_st.hdr_eem = 1'b0;
      end
    end else if (hit) begin
      if (w == txcd_pkg::SOFT_RST) begin
        next_st = txcd_defaults();
        next_st.srst = 1'b1;
      end else if (w[15:12] == txcd_pkg::P_FREQ) begin
        // Out-of-range value leaves the old one
        if (w[11:0] >= txcd_pkg::FREQ_MIN &&
            w[11:0] <= txcd_pkg::FREQ_MAX) begin
          next_st.freq = w[11:0];
        end
      end else if (w[15:13] == txcd_pkg::P_WAKE) begin
        {next_st.we, next_st.wm} = w[12:0];
      end else begin
        case (w[15:8])
          txcd_pkg::P_RATE: begin
            next_st.rate = w[7:0];
          end
          txcd_pkg::P_BATT: begin
            next_st.dwc = w[txcd_pkg::BATT_DWC];
            next_st.ebs = w[txcd_pkg::BATT_EBS];
            next_st.thr = w[4:0];
          end
          txcd_pkg::P_SLEEP: begin
            next_st.tail = w[7:0];
            slp = 1'b1;
          end
          txcd_pkg::P_BTN: begin
            {next_st.p4, next_st.deb, next_st.rpt, next_st.bc} = w[7:0];
          end
          txcd_pkg::P_PM: begin
            next_st.pm = w[7:0];
          end
          txcd_pkg::P_SEND: begin
            start = 1'b1;
            next_st.hdr_eem = 1'b1;
            next_st.nbytes = w[7:0];
          end
          default: begin
            // Words of other commands are ignored
          end
        endcase
      end
    end
    // Power sequencer
    if (start) begin
      next_st.bcnt = 8'h00;
      if (next_st.pm[txcd_pkg::PM_A1] || next_st.hdr_eem) begin
        next_st.seq = txcd_pkg::S_OSC;
        next_st.sosc = 1'b1;
        next_st.tail_on = 1'b0;
        next_st.tmr = st.osc ? 32'd0 : 32'(REF_WAIT_CYC - 1);
      end else begin
        next_st.seq = txcd_pkg::S_TX;
      end
    end else begin
      case (st.seq)
        txcd_pkg::S_OSC: begin
          if (st.tmr == 32'd0) begin
            next_st.ssyn = 1'b1;
            next_st.seq = txcd_pkg::S_LOCK;
            next_st.tmr = st.syn ? 32'd0 : 32'(LOCK_WAIT_CYC - 1);
          end else begin
            next_st.tmr = st.tmr - 32'd1;
          end
        end
        txcd_pkg::S_LOCK: begin
          if (st.tmr == 32'd0) begin
            if (st.pm[txcd_pkg::PM_A0] || st.hdr_eem) begin
              next_st.samp = 1'b1;
            end
            next_st.seq = txcd_pkg::S_TX;
          end else begin
            next_st.tmr = st.tmr - 32'd1;
          end
        end
        txcd_pkg::S_TX: begin
          // Counted bytes done: amp off, back to commands
          if (st.hdr_eem) begin
            if (st.bcnt == st.nbytes) begin
              next_st.samp = 1'b0;
              next_st.seq = txcd_pkg::S_IDLE;
            end else if (data_byte_valid) begin
              next_st.bcnt = st.bcnt + 8'h01;
            end
          end
        end
        default: begin
          next_st.seq = txcd_pkg::S_IDLE;
        end
      endcase
    end
    // Sleep ends host transmission and powers down
    if (slp) begin
      next_st.seq = txcd_pkg::S_IDLE;
      if (st.pm[txcd_pkg::PM_A0] && !st.pm[txcd_pkg::PM_EA]) begin
        next_st.samp = 1'b0;
      end
      if (st.pm[txcd_pkg::PM_A1] && !st.pm[txcd_pkg::PM_ES]) begin
        next_st.ssyn = 1'b0;
      end
      if (st.pm[txcd_pkg::PM_A1] && !st.pm[txcd_pkg::PM_EX]) begin
        next_st.tail_on = (w[7:0] != 8'h00);
        next_st.tail_cnt = 10'(int'(w[7:0]) * txcd_pkg::TAIL_UNIT_CYC - 1);
        next_st.sosc = 1'b0;
      end
    end else if (st.tail_on) begin
      // Clock tail counts down before the oscillator stops
      if (st.tail_cnt == 10'd0) begin
        next_st.tail_on = 1'b0;
      end else begin
        next_st.tail_cnt = st.tail_cnt - 10'd1;
      end
    end
    // Button debounce
    pr = ~{st.b2b, st.b1b};
    case (st.deb)
      2'b00: lim = 32'(DEB160_CYC);
      2'b01: lim = 32'(DEB40_CYC);
      2'b10: lim = 32'(DEB10_CYC);
      default: lim = 32'd0;
    endcase
    if (st.deb == 2'b11 || pr == st.bstab) begin
      next_st.dcnt = 32'd0;
      next_st.bstab = pr;
    end else if (st.dcnt >= lim - 32'd1) begin
      next_st.dcnt = 32'd0;
      next_st.bstab = pr;
    end else begin
      next_st.dcnt = st.dcnt + 32'd1;
    end
    next_st.busy = (st.deb != 2'b11) && (pr != next_st.bstab);
    // Button events, combined press, repeat while held
    combo = st.p4 && (&st.bstab);
    held = {combo, 1'b0, st.bstab[1] && !combo, st.bstab[0] && !combo};
    next_st.bprev = held;
    next_st.bevt = (held & ~st.bprev) | (held & st.rpt);
    next_st.irq_n = st.eemb || !(|next_st.bevt);
    // Event hold of the oscillator, set wins over clear
    if (slp) begin
      next_st.evh = 1'b0;
    end else if (st.pm[txcd_pkg::PM_DC] && !st.busy && !(|held)) begin
      next_st.evh = 1'b0;
    end
    if ((|next_st.bevt) || battery_monitor_low || wake_timeout) begin
      next_st.evh = 1'b1;
    end
    // Block enables
    next_st.osc = next_st.pm[txcd_pkg::PM_EX] || next_st.evh ||
                  next_st.busy || next_st.sosc ||
                  next_st.tail_on;
    next_st.syn = next_st.pm[txcd_pkg::PM_ES] || next_st.ssyn;
    next_st.amp = next_st.pm[txcd_pkg::PM_EA] || next_st.samp;
    next_st.cal = next_st.syn && !st.syn;
    next_st.key = next_st.amp && (!next_st.ook || st.tdb);
    next_st.txon = (next_st.seq == txcd_pkg::S_TX);
    next_st.stretch = next_st.hdr_eem && next_st.eemb &&
                      (next_st.seq == txcd_pkg::S_OSC ||
                       next_st.seq == txcd_pkg::S_LOCK);
    // Memory clock and bit timing
    run = st.eemb || st.txon;
    half = st.txon ? half_cyc(st.rate) : half_cyc(txcd_pkg::CMD_RD_R);
    if (!run) begin
      next_st.hcnt = 16'h0000;
      next_st.sck = 1'b0;
    end else if (st.hcnt >= half - 16'h0001) begin
      next_st.hcnt = 16'h0000;
      next_st.sck = !st.sck;
      next_st.btick = st.txon && !st.sck;
    end else begin
      next_st.hcnt = st.hcnt + 16'h0001;
    end
    // Wake timer recalibration period
    if (!st.pm[txcd_pkg::PM_ET] || st.dwc) begin
      next_st.rcnt = 32'd0;
    end else if (st.rcnt >= 32'(RECAL_CYC - 1)) begin
      next_st.rcnt = 32'd0;
      next_st.recal = 1'b1;
    end else begin
      next_st.rcnt = st.rcnt + 32'd1;
    end
    // Derived settings
    next_st.attdb = 5'(next_st.patt * txcd_pkg::ATT_STEP_DB);
    next_st.vlb = txcd_pkg::VLB_BASE_MV +
                  13'(next_st.thr * txcd_pkg::VLB_STEP_MV);
    case (band_sel)
      txcd_pkg::BAND_433: {next_st.c1, next_st.c2} =
        {txcd_pkg::C1_433, txcd_pkg::C2_433};
      txcd_pkg::BAND_868: {next_st.c1, next_st.c2} =
        {txcd_pkg::C1_868, txcd_pkg::C2_868};
      txcd_pkg::BAND_915: {next_st.c1, next_st.c2} =
        {txcd_pkg::C1_915, txcd_pkg::C2_915};
      default: {next_st.c1, next_st.c2} = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st <= txcd_defaults();
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state record
  assign osc_enable = st.osc;
  assign synth_enable = st.syn;
  assign amp_enable = st.amp;
  assign amp_key = st.key;
  assign vco_cal = st.cal;
  assign header_stretch = st.stretch;
  assign tx_active = st.txon;
  assign soft_reset = st.srst;
  assign battery_monitor_enable = st.pm[txcd_pkg::PM_EB];
  assign wake_timer_enable = st.pm[txcd_pkg::PM_ET];
  assign tx_bit_tick = st.btick;
  assign mem_sck = st.sck;
  assign wake_recal = st.recal;
  assign freq_field = st.freq;
  assign freq_c1 = st.c1;
  assign freq_c2 = st.c2;
  assign rate_field = st.rate;
  assign power_atten_field = st.patt;
  assign atten_db = st.attdb;
  assign battery_threshold_field = st.thr;
  assign threshold_mv = st.vlb;
  assign clock_tail_count = st.tail;
  assign wake_mantissa = st.wm;
  assign wake_exponent = st.we;
  assign bit_sync_enable = st.ebs;
  assign debounce_select = st.deb;
  assign pullup_enable = !st.bc;
  assign button_events = st.bevt;
  assign interrupt_out_n = st.irq_n;

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_freq_keep;
    @(posedge clk_sys) disable iff (!resetn)
    (cmd_valid && !cmd_short && !st.hdr_eem && cmd_word[15:12] == 4'ha &&
     cmd_word[11:0] > 12'hf3f) |=> $stable(freq_field);
  endproperty
  a_freq_keep: assert property (p_freq_keep)
    else $error("Out-of-range carrier value was stored");

  property p_soft_reset;
    @(posedge clk_sys) disable iff (!resetn)
    (cmd_valid && !cmd_short && cmd_word == 16'hfe00 && !st.txon)
      |=> soft_reset && freq_field == 12'h7d0;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("Software reset word did not restore defaults");

  property p_vco_cal;
    @(posedge clk_sys) disable iff (!resetn)
    $rose(synth_enable) |-> vco_cal ##1 !vco_cal;
  endproperty
  a_vco_cal: assert property (p_vco_cal)
    else $error("Synthesizer start without single calibration pulse");

  property p_amp_off_count;
    @(posedge clk_sys) disable iff (!resetn)
    (st.seq == txcd_pkg::S_TX && st.hdr_eem && st.bcnt == st.nbytes &&
     !st.pm[txcd_pkg::PM_EA] && !cmd_valid) |=> !amp_enable && !tx_active;
  endproperty
  a_amp_off_count: assert property (p_amp_off_count)
    else $error("Amplifier left on after counted bytes");

  property p_atten;
    @(posedge clk_sys) disable iff (!resetn)
    ##1 atten_db == 5'(power_atten_field * 3);
  endproperty
  a_atten: assert property (p_atten)
    else $error("Attenuation does not match power code");

  property p_vlb;
    @(posedge clk_sys) disable iff (!resetn)
    ##1 threshold_mv == 13'd2250 + 13'(battery_threshold_field * 100);
  endproperty
  a_vlb: assert property (p_vlb)
    else $error("Battery threshold does not match field");

  property p_deb_osc;
    @(posedge clk_sys) disable iff (!resetn)
    st.busy |-> osc_enable;
  endproperty
  a_deb_osc: assert property (p_deb_osc)
    else $error("Oscillator stopped during debounce");

  property p_sleep_amp;
    @(posedge clk_sys) disable iff (!resetn)
    (cmd_valid && !cmd_short && cmd_word[15:8] == 8'hc4 && !st.hdr_eem &&
     st.pm[txcd_pkg::PM_A0] && !st.pm[txcd_pkg::PM_EA])
      |=> !amp_enable && !tx_active;
  endproperty
  a_sleep_amp: assert property (p_sleep_amp)
    else $error("Sleep did not drop the amplifier");

  property p_stretch;
    @(posedge clk_sys) disable iff (!resetn)
    header_stretch |-> !tx_active && osc_enable;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("Header stretch while transmitting or oscillator off");

  property p_ook;
    @(posedge clk_sys) disable iff (!resetn)
    (amp_enable && !st.ook) |-> amp_key;
  endproperty
  a_ook: assert property (p_ook)
    else $error("Amplifier keyed off outside on-off keying");

endmodule : txcd_core

// [test/txcd_host.sv]
// Host controller model that issues command words to the decoder
`timescale 1ns/1ps
module txcd_host (
  // Clock
  input wire logic clk_sys,
  // Command port
  output logic cmd_valid,
  output logic cmd_short,
  output logic [15:0] cmd_word
);
  // Idle port at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_short = 1'b0;
    cmd_word = 16'h0000;
  end
  // One word per strobe; the word is only valid in its strobe cycle
  task automatic send(input logic [15:0] w, input logic s);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_short <= s;
    cmd_word <= w;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_word <= ~w;
  endtask : send
endmodule : txcd_host

// [test/tx_control_command_decoder_bench.sv]
// Self-checking bench for the transmit command decoder
`timescale 1ns/1ps
module tx_control_command_decoder_bench;
  // Clock, reset and pins
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic data_byte_valid = 1'b0, eeprom_mode_pin = 1'b0, tx_data_pin = 1'b0;
  logic button_one_input = 1'b1, button_two_input = 1'b1;
  logic battery_monitor_low = 1'b0, wake_timeout = 1'b0;
  logic [1:0] band_sel = 2'b01;
  // Outputs under test
  logic cmd_valid, cmd_short, osc_enable, synth_enable, amp_enable, amp_key;
  logic vco_cal, tx_active, soft_reset, bit_sync_enable, pullup_enable;
  logic [15:0] cmd_word;
  logic [11:0] freq_field;
  logic [1:0] freq_c1, debounce_select;
  logic [5:0] freq_c2;
  logic [7:0] rate_field, clock_tail_count, wake_mantissa;
  logic [2:0] power_atten_field;
  logic [4:0] atten_db, wake_exponent;
  logic [12:0] threshold_mv;
  logic header_stretch, interrupt_out_n;
  logic [3:0] button_events;
  // Bookkeeping
  int n_mismatch = 0, comparisons = 0, cycles = 0, ncal = 0;
  logic [15:0] fw [5] = '{16'ha610, 16'ha05f, 16'haf40, 16'ha060, 16'haf3f};
  logic [15:0] fe [5] = '{16'h610, 16'h610, 16'h610, 16'h060, 16'hf3f};

  txcd_host HOST (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
    .cmd_short(cmd_short), .cmd_word(cmd_word));
  txcd_core #(.DEB160_CYC(40), .DEB40_CYC(20), .DEB10_CYC(10),
    .RECAL_CYC(100), .REF_WAIT_CYC(5), .LOCK_WAIT_CYC(8)) DUT (.*,
    .battery_monitor_enable(), .wake_timer_enable(),
    .tx_bit_tick(), .mem_sck(), .wake_recal(), .battery_threshold_field());

  ////////////////////////////////////////////////////////////////////////
  // Clock, calibration pulse count and hang limit
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (vco_cal === 1'b1) ncal++;
    if (cycles == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // Compare one value
  task automatic chk(input string n, input logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Wait n edges and let the last one land
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle
  // Send a word and wait until its fields show
  task automatic cmd(input logic [15:0] w, input logic s);
    HOST.send(w, s);
    settle(1);
  endtask : cmd
  // Verdict
  task automatic complete_run;
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    settle(1);
    chk("freq", 16'h7d0, 16'(freq_field));
    chk("tail", 16'h10, 16'(clock_tail_count));
    chk("vlb", 16'd2250, 16'(threshold_mv));
    chk("osc", 16'h1, 16'(osc_enable));
    chk("c", 16'h12b, {8'(freq_c1), 8'(freq_c2)});
    // Band constants follow the band select one cycle late
    @(posedge clk_sys);
    band_sel <= 2'b11;
    settle(1);
    chk("c", 16'h31e, {8'(freq_c1), 8'(freq_c2)});
    @(posedge clk_sys);
    band_sel <= 2'b10;
    settle(1);
    chk("c", 16'h22b, {8'(freq_c1), 8'(freq_c2)});
    for (int i = 0; i < 5; i++) begin
      cmd(fw[i], 1'b0);
      chk("freq", fe[i], 16'(freq_field));
    end
    cmd(16'hc823, 1'b0);
    chk("rate", 16'h23, 16'(rate_field));
    cmd(16'he5ab, 1'b0);
    chk("wake", 16'h05ab, {8'(wake_exponent), wake_mantissa});
    cmd(16'hca41, 1'b0);
    chk("btn", 16'h8000, {debounce_select, 14'(pullup_enable)});
    for (int t = 0; t < 32; t += 31) begin
      cmd(16'hc220 | 16'(t), 1'b0);
      chk("vlb", 16'(2250 + 100 * t), 16'(threshold_mv));
      chk("sync", 16'h1, 16'(bit_sync_enable));
    end
    for (int c = 0; c < 8; c++) begin
      cmd(16'hb0 | 16'(c), 1'b1);
      chk("att", 16'(3 * c), 16'(atten_db));
    end
    cmd(16'hc0c0, 1'b0);
    cmd(16'hc6, 1'b1);
    for (int i = 0; i < 40 && tx_active !== 1'b1; i++) settle(1);
    chk("pwr", 16'h3, {synth_enable, amp_enable});
    chk("cal", 16'h1, 16'(ncal));
    cmd(16'hb8, 1'b1);
    settle(4);
    chk("key", 16'h0, 16'(amp_key));
    @(posedge clk_sys);
    tx_data_pin <= 1'b1;
    settle(4);
    chk("key", 16'h1, 16'(amp_key));
    cmd(16'hc420, 1'b0);
    chk("sleep", 16'h1,
        {synth_enable, amp_enable, tx_active, osc_enable});
    settle(140);
    chk("osc", 16'h0, 16'(osc_enable));
    // Memory mode header of two counted bytes
    @(posedge clk_sys);
    eeprom_mode_pin <= 1'b1;
    cmd(16'hc602, 1'b0);
    chk("strch", 16'h1, {tx_active, header_stretch});
    for (int i = 0; i < 40 && tx_active !== 1'b1; i++) settle(1);
    chk("mpwr", 16'h3, {synth_enable, amp_enable});
    @(posedge clk_sys);
    data_byte_valid <= 1'b1;
    repeat (2) @(posedge clk_sys);
    data_byte_valid <= 1'b0;
    eeprom_mode_pin <= 1'b0;
    settle(2);
    chk("mend", 16'h0, {amp_enable, tx_active});
    cmd(16'ha123, 1'b0);
    chk("freq", 16'h123, 16'(freq_field));
    // Software reset pulse and restored defaults
    HOST.send(16'hfe00, 1'b0);
    #1;
    chk("srst", 16'h1, 16'(soft_reset));
    settle(2);
    chk("rst", 16'h7d0, 16'(freq_field));
    // Buttons: 10-cycle debounce, combine on, no repeat
    cmd(16'hcac0, 1'b0);
    @(posedge clk_sys);
    button_one_input <= 1'b0;
    settle(12);
    chk("evt", 16'h0, 16'(button_events));
    settle(1);
    chk("evt", 16'h1, 16'(button_events));
    chk("irq", 16'h0, 16'(interrupt_out_n));
    settle(1);
    chk("evt", 16'h0, 16'(button_events));
    @(posedge clk_sys);
    button_two_input <= 1'b0;
    settle(13);
    chk("evt", 16'h8, 16'(button_events));
    @(posedge clk_sys);
    button_one_input <= 1'b1;
    button_two_input <= 1'b1;
    complete_run();
  end
endmodule : tx_control_command_decoder_bench
